// >>> hw/mac_pkg.sv
package mac_pkg;

    // ----------------------------------------------------------------
    // datapath widths
    // ----------------------------------------------------------------
    localparam int OPERAND_W = 12;
    localparam int PRODUCT_W = 24;
    localparam int LOW_W     = 12;
    localparam int HIGH_W    = 12;
    localparam int EXT_W     = 3;
    localparam int ACC_W     = LOW_W + HIGH_W + EXT_W;

    // ----------------------------------------------------------------
    // field positions inside the accumulator
    // ----------------------------------------------------------------
    localparam int LOW_LSB  = 0;
    localparam int HIGH_LSB = LOW_W;
    localparam int EXT_LSB  = LOW_W + HIGH_W;

    // ----------------------------------------------------------------
    // rounding constant: one at top bit of the product's lower half
    // ----------------------------------------------------------------
    localparam logic [ACC_W-1:0] ROUND_ADD = 27'h0000800;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [ACC_W-1:0]     ACC_RESET     = 27'h0000000;
    localparam logic [OPERAND_W-1:0] OPERAND_RESET = 12'h000;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int             ADDR_W   = 4;
    localparam logic [ADDR_W-1:0] REG_ACC  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_OPER = 4'h4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h8;
    localparam logic [ADDR_W-1:0] REG_CMD  = 4'hc;

    // control readback bit positions
    localparam int CTRL_RND_BIT = 0;
    localparam int CTRL_TC_BIT  = 1;
    localparam int CTRL_ACC_BIT = 2;
    localparam int CTRL_SUB_BIT = 3;

    // command register: write one to clear the accumulator unless a result edge comes in the same cycle
    localparam int CMD_CLEAR_BIT = 0;

    // ----------------------------------------------------------------
    // bus responses
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : mac_pkg

// >>> hw/mac_top.sv
module mac_top
    import mac_pkg::*;
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 operand_a_clk,
    input  wire logic                 operand_b_clk,
    input  wire logic                 result_clk,
    input  wire logic [OPERAND_W-1:0] operand_a,
    input  wire logic [OPERAND_W-1:0] operand_b,
    input  wire logic                 round_control,
    input  wire logic                 signed_format_select,
    input  wire logic                 accumulate_control,
    input  wire logic                 subtract_control,
    input  wire logic                 preload_control,
    input  wire logic                 extension_output_enable_n,
    input  wire logic                 high_output_enable_n,
    input  wire logic                 low_output_enable_n,
    input  wire logic [LOW_W-1:0]     result_low_section_i,
    output logic      [LOW_W-1:0]     result_low_section_o,
    output logic                      result_low_section_oe,
    input  wire logic [HIGH_W-1:0]    result_high_section_i,
    output logic      [HIGH_W-1:0]    result_high_section_o,
    output logic                      result_high_section_oe,
    input  wire logic [EXT_W-1:0]     result_extension_section_i,
    output logic      [EXT_W-1:0]     result_extension_section_o,
    output logic                      result_extension_section_oe,
    input  wire logic [31:0]          s_axi_awaddr,
    input  wire logic [2:0]           s_axi_awprot,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic      [1:0]           s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [31:0]          s_axi_araddr,
    input  wire logic [2:0]           s_axi_arprot,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic      [31:0]          s_axi_rdata,
    output logic      [1:0]           s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);

    // ----------------------------------------------------------------
    // clock pin edge detection
    // ----------------------------------------------------------------
    logic a_clk_q;
    logic b_clk_q;
    logic or_clk_q;
    logic r_clk_q;
    wire  or_clk = operand_a_clk | operand_b_clk;
    wire  a_rise  = operand_a_clk & ~a_clk_q;
    wire  b_rise  = operand_b_clk & ~b_clk_q;
    wire  or_rise = or_clk & ~or_clk_q;
    wire  r_rise  = result_clk & ~r_clk_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_clk_q  <= 1'b0;
            b_clk_q  <= 1'b0;
            or_clk_q <= 1'b0;
            r_clk_q  <= 1'b0;
        end else begin
            a_clk_q  <= operand_a_clk;
            b_clk_q  <= operand_b_clk;
            or_clk_q <= or_clk;
            r_clk_q  <= result_clk;
        end
    end

    // ----------------------------------------------------------------
    // operand and control registers
    // ----------------------------------------------------------------
    logic [OPERAND_W-1:0] opa_q;
    logic [OPERAND_W-1:0] opb_q;
    logic                 rnd_q;
    logic                 tc_q;
    logic                 accum_q;
    logic                 sub_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opa_q <= OPERAND_RESET;
        end else if (a_rise) begin
            opa_q <= operand_a;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opb_q <= OPERAND_RESET;
        end else if (b_rise) begin
            opb_q <= operand_b;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rnd_q   <= 1'b0;
            tc_q    <= 1'b0;
            accum_q <= 1'b0;
            sub_q   <= 1'b0;
        end else if (or_rise) begin
            rnd_q   <= round_control;
            tc_q    <= signed_format_select;
            accum_q <= accumulate_control;
            sub_q   <= subtract_control;
        end
    end

    // ----------------------------------------------------------------
    // multiplier and accumulator arithmetic
    // ----------------------------------------------------------------
    localparam int EXTEND_W = ACC_W - OPERAND_W;

    logic [ACC_W-1:0]   acc_q;
    logic [ACC_W-1:0]   acc_d;
    logic [2*ACC_W-1:0] full_prod;

    wire [EXTEND_W-1:0] a_fill = tc_q ? {EXTEND_W{opa_q[OPERAND_W-1]}}
                                      : {EXTEND_W{1'b0}};
    wire [EXTEND_W-1:0] b_fill = tc_q ? {EXTEND_W{opb_q[OPERAND_W-1]}}
                                      : {EXTEND_W{1'b0}};
    wire [ACC_W-1:0]    a_ext  = {a_fill, opa_q};
    wire [ACC_W-1:0]    b_ext  = {b_fill, opb_q};

    // full 54-bit product of the operands extended to 27 bits (sign fill only when tc_q)
    assign full_prod = a_ext * b_ext;
    wire [PRODUCT_W-1:0] product = full_prod[PRODUCT_W-1:0];
    wire [ACC_W-1:0]     prod_ext =
        {{(ACC_W-PRODUCT_W){tc_q & product[PRODUCT_W-1]}}, product};

    wire [ACC_W-1:0] prod_rnd = rnd_q ? ACC_W'(prod_ext + ROUND_ADD)
                                      : prod_ext;

    wire [ACC_W-1:0] acc_sum  = ACC_W'(prod_rnd + acc_q);
    wire [ACC_W-1:0] acc_diff = ACC_W'(prod_rnd - acc_q);
    wire [ACC_W-1:0] acc_next = !accum_q ? prod_rnd
                              : (sub_q ? acc_diff : acc_sum);

    // ----------------------------------------------------------------
    // accumulator sections and preload
    // ----------------------------------------------------------------
    logic clear_pulse;

    wire load_low  = preload_control & low_output_enable_n;
    wire load_high = preload_control & high_output_enable_n;
    wire load_ext  = preload_control & extension_output_enable_n;

    always_comb begin
        acc_d = acc_q;
        if (r_rise) begin
            if (!preload_control) begin
                acc_d = acc_next;
            end else begin
                if (load_low) begin
                    acc_d[LOW_LSB +: LOW_W] = result_low_section_i;
                end
                if (load_high) begin
                    acc_d[HIGH_LSB +: HIGH_W] = result_high_section_i;
                end
                if (load_ext) begin
                    acc_d[EXT_LSB +: EXT_W] = result_extension_section_i;
                end
            end
        end else if (clear_pulse) begin
            acc_d = ACC_RESET;
        end
    end

    // state moves only at result edges or on a clear command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_q <= ACC_RESET;
        end else begin
            acc_q <= acc_d;
        end
    end

    assign result_low_section_o       = acc_q[LOW_LSB +: LOW_W];
    assign result_high_section_o      = acc_q[HIGH_LSB +: HIGH_W];
    assign result_extension_section_o = acc_q[EXT_LSB +: EXT_W];

    // enables act on drivers without a clock
    assign result_low_section_oe  = ~preload_control & ~low_output_enable_n;
    assign result_high_section_oe = ~preload_control & ~high_output_enable_n;
    assign result_extension_section_oe =
        ~preload_control & ~extension_output_enable_n;

    // ----------------------------------------------------------------
    // register bus slave
    // ----------------------------------------------------------------
    logic              aw_full_q;
    logic              w_full_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    wire aw_take  = s_axi_awvalid & ~aw_full_q;
    wire w_take   = s_axi_wvalid & ~w_full_q;
    wire do_write = aw_full_q & w_full_q & ~bvalid_q;
    wire ar_take  = s_axi_arvalid & ~rvalid_q;

    wire [ADDR_W-1:0] raddr   = s_axi_araddr[ADDR_W-1:0];
    wire              w_hit   = (waddr_q == REG_CMD);
    wire              r_hit   = (raddr == REG_ACC) | (raddr == REG_OPER)
                              | (raddr == REG_CTRL) | (raddr == REG_CMD);
    wire              w_upper = |s_axi_awaddr[31:ADDR_W];
    logic             waddr_bad_q;

    wire [31:0] ctrl_word = {28'h0000000, sub_q, accum_q, tc_q, rnd_q};
    wire [31:0] oper_word = {4'h0, opb_q, 4'h0, opa_q};
    wire [31:0] acc_word  = {{(32-ACC_W){1'b0}}, acc_q};
    wire [31:0] rd_mux    = (raddr == REG_ACC)  ? acc_word
                          : (raddr == REG_OPER) ? oper_word
                          : (raddr == REG_CTRL) ? ctrl_word
                          : 32'h00000000;
    wire        r_ok      = r_hit & ~(|s_axi_araddr[31:ADDR_W]);

    assign clear_pulse = do_write & w_hit & ~waddr_bad_q & wstrb_q[0]
                       & wdata_q[CMD_CLEAR_BIT];

    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready  = ~w_full_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q   <= 1'b0;
            waddr_q     <= '0;
            waddr_bad_q <= 1'b0;
        end else if (aw_take) begin
            aw_full_q   <= 1'b1;
            waddr_q     <= s_axi_awaddr[ADDR_W-1:0];
            waddr_bad_q <= w_upper;
        end else if (do_write) begin
            aw_full_q   <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wdata_q  <= 32'h00000000;
            wstrb_q  <= 4'h0;
        end else if (w_take) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (do_write) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (w_hit & ~waddr_bad_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= r_ok ? rd_mux : 32'h00000000;
            rresp_q  <= r_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule : mac_top

// >>> tb/mac_checker.sv
module mac_checker
    import mac_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              result_clk,
    input wire logic              preload_control,
    input wire logic              low_output_enable_n,
    input wire logic              high_output_enable_n,
    input wire logic              extension_output_enable_n,
    input wire logic [LOW_W-1:0]  result_low_section_i,
    input wire logic [LOW_W-1:0]  result_low_section_o,
    input wire logic              result_low_section_oe,
    input wire logic [HIGH_W-1:0] result_high_section_o,
    input wire logic              result_high_section_oe,
    input wire logic [EXT_W-1:0]  result_extension_section_o,
    input wire logic              result_extension_section_oe,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [31:0]       s_axi_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [ACC_W-1:0] acc_w;
    assign acc_w = {result_extension_section_o, result_high_section_o,
                    result_low_section_o};
    sequence rise_s;
        !result_clk ##1 result_clk;
    endsequence
    low_oe_a: assert property (
        result_low_section_oe == (!preload_control && !low_output_enable_n))
        else $error("low enable wrong");
    high_oe_a: assert property (
        result_high_section_oe == (!preload_control && !high_output_enable_n))
        else $error("high enable wrong");
    ext_oe_a: assert property (
        result_extension_section_oe ==
        (!preload_control && !extension_output_enable_n))
        else $error("extension enable wrong");
    all_float_a: assert property (
        preload_control |-> !(result_low_section_oe ||
        result_high_section_oe || result_extension_section_oe))
        else $error("driver on during preload");
    pre_load_a: assert property (
        rise_s ##0 (preload_control && low_output_enable_n) |=>
        result_low_section_o == $past(result_low_section_i))
        else $error("preload not taken");
    pre_keep_a: assert property (
        rise_s ##0 (preload_control && !low_output_enable_n) |=>
        $stable(result_low_section_o))
        else $error("unselected section changed");
    acc_hold_a: assert property (
        !$rose(result_clk) |=> $stable(acc_w) || s_axi_bvalid)
        else $error("accumulator changed without edge");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    r_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule : mac_checker

// >>> tb/mac_pin_model.sv
module mac_pin_model #(
    parameter int W = 12
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         preload_control,
    input  wire logic         enable_n,
    input  wire logic [W-1:0] dut_o,
    input  wire logic         dut_oe,
    input  wire logic [W-1:0] drive_val,
    output logic      [W-1:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] last_q;
    logic         drv;
    assign drv = preload_control && enable_n;
    // undriven wire toggles every clock, holds all ones while rst_n is low
    assign pin = dut_oe ? dut_o : (drv ? drive_val : ~last_q);
    always_ff @(posedge clk) begin
        last_q <= rst_n ? pin : '0;
    end
endmodule : mac_pin_model

// >>> tb/multiply_accumulate_12bit_tb_top.sv
module multiply_accumulate_12bit_tb_top
    import mac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn, operand_a_clk, operand_b_clk, result_clk, round_control;
    logic signed_format_select, accumulate_control, subtract_control;
    logic preload_control, extension_output_enable_n, high_output_enable_n;
    logic low_output_enable_n, result_low_section_oe, result_high_section_oe;
    logic result_extension_section_oe;
    logic [11:0] operand_a, operand_b, result_low_section_i, dl, dh;
    logic [11:0] result_low_section_o, result_high_section_i;
    logic [11:0] result_high_section_o;
    logic [2:0]  result_extension_section_i, result_extension_section_o, dx;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [2:0]  s_axi_awprot = 3'h0;
    logic [2:0]  s_axi_arprot = 3'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] xs = 32'h8;
    logic [31:0] m_opr;
    logic [26:0] m_acc;
    logic [3:0]  m_ctl;
    int          err_count = 0;
    int          checked = 0;
    always #5 aclk = ~aclk;
    mac_top uut (.*);
    mac_pin_model #(.W(12)) pl (.clk(aclk), .rst_n(aresetn),
        .preload_control(preload_control), .enable_n(low_output_enable_n),
        .dut_o(result_low_section_o), .dut_oe(result_low_section_oe),
        .drive_val(dl), .pin(result_low_section_i));
    mac_pin_model #(.W(12)) ph (.clk(aclk), .rst_n(aresetn),
        .preload_control(preload_control), .enable_n(high_output_enable_n),
        .dut_o(result_high_section_o), .dut_oe(result_high_section_oe),
        .drive_val(dh), .pin(result_high_section_i));
    mac_pin_model #(.W(3)) px (.clk(aclk), .rst_n(aresetn),
        .preload_control(preload_control),
        .enable_n(extension_output_enable_n),
        .dut_o(result_extension_section_o),
        .dut_oe(result_extension_section_oe),
        .drive_val(dx), .pin(result_extension_section_i));
    // ----
    // helpers
    // ----
    function automatic logic [31:0] xr();
        xs = xs ^ (xs << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
        return xs;
    endfunction : xr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic tmo();
        err_count++;
        $display("BAD %0t timeout", $time);
        final_report();
    endtask : tmo
    task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
        int n;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                break;
            end
        end
        if (n == 40) tmo();
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                break;
            end
        end
        if (n == 40) tmo();
    endtask : rd
    task automatic pins();
        chk({5'h0, result_extension_section_i, result_high_section_i,
             result_low_section_i}, {5'h0, m_acc});
    endtask : pins
    task automatic op(input logic [11:0] a, b, input logic [3:0] c);
        logic signed [26:0] sa, sb;
        logic [26:0]        p;
        sa = $signed(a);
        sb = $signed(b);
        operand_a <= a;
        operand_b <= b;
        {subtract_control, accumulate_control, signed_format_select,
         round_control} <= c;
        operand_a_clk <= 1'b1;
        operand_b_clk <= 1'b1;
        @(posedge aclk);
        operand_a_clk <= 1'b0;
        operand_b_clk <= 1'b0;
        result_clk    <= 1'b1;
        @(posedge aclk);
        result_clk <= 1'b0;
        p = c[1] ? sa * sb : {15'h0, a} * {15'h0, b};
        if (c[0]) p = p + ROUND_ADD;
        m_acc = !c[2] ? p : (c[3] ? p - m_acc : p + m_acc);
        m_opr = {4'h0, b, 4'h0, a};
        m_ctl = c;
        @(posedge aclk);
        pins();
    endtask : op
    // ----
    // main sequence
    // ----
    initial begin
        logic [31:0] d, v;
        logic [1:0]  r;
        {aresetn, operand_a_clk, operand_b_clk, result_clk} = 4'h0;
        {round_control, signed_format_select, accumulate_control} = 3'h0;
        {subtract_control, preload_control, s_axi_awvalid} = 3'h0;
        {extension_output_enable_n, high_output_enable_n} = 2'h0;
        {low_output_enable_n, s_axi_wvalid, s_axi_bready} = 3'h1;
        {s_axi_arvalid, s_axi_rready} = 2'h1;
        {operand_a, operand_b, dl, dh, dx} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        m_acc = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(32'(REG_ACC), d, r);
        chk(d, 32'h0);
        op(12'h800, 12'h800, 4'h2);
        op(12'hfff, 12'hfff, 4'h1);
        for (int i = 0; i < 32; i++) begin
            op(12'(xr()), 12'(xr()), i < 16 ? 4'(i) : 4'(xr()));
            rd(32'(REG_ACC), d, r);
            chk(d, {5'h0, m_acc});
            rd(32'(REG_CTRL), d, r);
            chk(d, {28'h0, m_ctl});
        end
        $display("test arithmetic done");
        operand_a <= 12'h5a5;
        {subtract_control, accumulate_control, signed_format_select,
         round_control} <= 4'h9;
        operand_a_clk <= 1'b1;
        @(posedge aclk);
        operand_a_clk <= 1'b0;
        @(posedge aclk);
        rd(32'(REG_OPER), d, r);
        chk(d, {m_opr[31:12], 12'h5a5});
        rd(32'(REG_CTRL), d, r);
        chk(d, 32'h9);
        $display("test operand clock done");
        for (int i = 0; i < 8; i++) begin
            v = xr();
            preload_control <= 1'b1;
            {extension_output_enable_n, high_output_enable_n,
             low_output_enable_n} <= 3'(i);
            {dx, dh, dl} <= v[26:0];
            @(posedge aclk);
            result_clk <= 1'b1;
            @(posedge aclk);
            result_clk <= 1'b0;
            chk({29'h0, result_extension_section_oe, result_high_section_oe,
                 result_low_section_oe}, 32'h0);
            if (i[0]) m_acc[11:0] = v[11:0];
            if (i[1]) m_acc[23:12] = v[23:12];
            if (i[2]) m_acc[26:24] = v[26:24];
            preload_control <= 1'b0;
            {extension_output_enable_n, high_output_enable_n,
             low_output_enable_n} <= 3'h0;
            @(posedge aclk);
            pins();
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge aclk);
            {extension_output_enable_n, high_output_enable_n,
             low_output_enable_n} <= 3'(i);
            #1;
            chk({29'h0, result_extension_section_oe, result_high_section_oe,
                 result_low_section_oe}, {29'h0, ~3'(i)});
        end
        $display("test sections done");
        @(posedge aclk);
        wr(32'(REG_ACC), 32'h5, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        rd(32'h10, d, r);
        chk({d[29:0], r}, {30'h0, RESP_SLVERR});
        wr(32'(REG_CMD), 32'h1, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        rd(32'(REG_ACC), d, r);
        chk(d, 32'h0);
        $display("test bus done");
        final_report();
    end
endmodule : multiply_accumulate_12bit_tb_top

bind mac_top mac_checker chk (.*);
